// ### core/tfd_framer.sv
// Framer F-bit data link: multiframe formatter, synchroniser and bit-oriented codes
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module tfd_framer import tfd_pkg::*; #(
  parameter int FRAMER_NUM = 1
) (
  // Clock, enable, reset
  input wire logic CLK,
  input wire logic CE,
  input wire logic RST_B,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [14:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // F-bit stream
  input wire logic F_STB,
  input wire logic TX_FBIT_IN,
  input wire logic RX_FBIT,
  input wire logic RX_DL_SLOT,
  output logic TX_FBIT,
  output logic TX_MF_SYNC
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  // ==========================================
  // Register file
  logic [7:0] mode_ctrl, tx_ctrl1, tx_ctrl2, tx_ctrl3, tx_hdlc2, tx_fdl, tx_boc;
  logic [7:0] rx_ctrl1, rx_t1_ctrl2, rx_boc_ctrl, rx_boc_val, tx_stat1, rx_stat7;
  logic [23:0] tx_msg, rx_msg;
  logic [12:0] idx;
  logic [7:0] rd_val;
  logic rd_hit, acc, wr_go;
  logic [7:0] wd;
  assign idx = PADDR[14:2] - 13'((FRAMER_NUM - 1) * FRAMER_STRIDE);
  assign acc = PSEL && PENABLE && !PREADY && CE;
  assign wr_go = PSEL && PENABLE && PREADY && PWRITE && rd_hit && CE;
  assign wd = PWDATA[7:0];

  always_comb begin
    rd_hit = (PADDR[1:0] == 2'b00);
    case (idx)
      IDX_RX_MSG1: rd_val = rx_msg[7:0];
      IDX_RX_MSG2: rd_val = rx_msg[15:8];
      IDX_RX_MSG3: rd_val = rx_msg[23:16];
      IDX_RX_BOC_VAL: rd_val = rx_boc_val;
      IDX_RX_BOC_CTRL: rd_val = rx_boc_ctrl;
      IDX_RX_STAT7: rd_val = rx_stat7;
      IDX_RX_CTRL1: rd_val = rx_ctrl1;
      IDX_RX_T1_CTRL2: rd_val = rx_t1_ctrl2;
      IDX_MODE_CTRL: rd_val = mode_ctrl;
      IDX_TX_HDLC2: rd_val = tx_hdlc2;
      IDX_TX_FDL: rd_val = tx_fdl;
      IDX_TX_BOC: rd_val = tx_boc;
      IDX_TX_MSG1: rd_val = tx_msg[7:0];
      IDX_TX_MSG2: rd_val = tx_msg[15:8];
      IDX_TX_MSG3: rd_val = tx_msg[23:16];
      IDX_TX_CTRL1: rd_val = tx_ctrl1;
      IDX_TX_CTRL2: rd_val = tx_ctrl2;
      IDX_TX_CTRL3: rd_val = tx_ctrl3;
      IDX_TX_STAT1: rd_val = tx_stat1;
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // One wait state on every access
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      PREADY <= acc;
      PSLVERR <= acc && !rd_hit;
      if (acc && !PWRITE) begin
        PRDATA <= {24'h00_0000, rd_val};
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      mode_ctrl <= RST_MODE;
      tx_ctrl1 <= RST_REG;
      tx_ctrl2 <= RST_REG;
      tx_ctrl3 <= RST_REG;
      tx_hdlc2 <= RST_REG;
      tx_fdl <= RST_REG;
      tx_boc <= RST_REG;
      tx_msg <= {3{RST_REG}};
      rx_ctrl1 <= RST_REG;
      rx_t1_ctrl2 <= RST_REG;
      rx_boc_ctrl <= RST_REG;
    end else if (wr_go) begin
      case (idx)
        IDX_MODE_CTRL: mode_ctrl <= wd;
        IDX_TX_CTRL1: tx_ctrl1 <= wd;
        IDX_TX_CTRL2: tx_ctrl2 <= wd;
        IDX_TX_CTRL3: tx_ctrl3 <= wd;
        IDX_TX_HDLC2: tx_hdlc2 <= wd;
        IDX_TX_FDL: tx_fdl <= wd;
        IDX_TX_BOC: tx_boc <= wd;
        IDX_TX_MSG1: tx_msg[7:0] <= wd;
        IDX_TX_MSG2: tx_msg[15:8] <= wd;
        IDX_TX_MSG3: tx_msg[23:16] <= wd;
        IDX_RX_CTRL1: rx_ctrl1 <= wd;
        IDX_RX_T1_CTRL2: rx_t1_ctrl2 <= wd;
        IDX_RX_BOC_CTRL: rx_boc_ctrl <= wd;
        default: ;
      endcase
    end
  end

  // ==========================================
  // Transmit multiframe formatter
  logic t1, tx_pt, slc_on, fstb, sent_set, boc_tx_on;
  logic [6:0] tx_frame;
  logic [5:0] fs_k;
  logic [23:0] shadow;
  logic slc_bit, boc_bit;
  tfd_boc_t boc_state;
  logic [3:0] boc_cnt;
  logic send_bitcode, send_bitcode_q;
  logic [15:0] boc_word;
  assign t1 = mode_ctrl[B_T1_MODE];
  assign fstb = F_STB && CE;
  assign tx_pt = tx_ctrl1[B_TX_PT];
  assign slc_on = t1 && tx_ctrl2[B_TX_SLC_EN] && !tx_ctrl2[B_TX_SRC] && tx_ctrl3[B_TX_FRM] && !tx_pt;
  assign fs_k = tx_frame[6:1];
  assign sent_set = fstb && slc_on && (tx_frame == MF_LAST);
  assign send_bitcode = tx_hdlc2[B_SEND_BITCODE];
  assign boc_tx_on = t1 && !tx_ctrl3[B_TX_FRM];
  assign boc_word = {8'hFF, 1'b0, tx_boc[5:0], 1'b0};

  always_comb begin
    if (!tx_frame[0]) begin
      slc_bit = ~fs_k[0];
    end else if (fs_k < ALIGN_BITS) begin
      slc_bit = ALIGN_PAT[fs_k[3:0]];
    end else begin
      slc_bit = shadow[5'(fs_k - ALIGN_BITS)];
    end
    boc_bit = (boc_state == BOC_SEND) ? boc_word[boc_cnt] : 1'b1;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_frame <= 7'd0;
      TX_MF_SYNC <= 1'b0;
    end else if (fstb) begin
      tx_frame <= (tx_frame == MF_LAST) ? 7'd0 : tx_frame + 7'd1;
      TX_MF_SYNC <= (tx_frame == 7'd0);
    end
  end

  // Shadow keeps a multiframe coherent; stale values repeat when not rewritten
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      shadow <= {3{RST_REG}};
    end else if (fstb && tx_frame == 7'd0) begin
      shadow <= tx_msg;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      TX_FBIT <= 1'b0;
    end else if (fstb) begin
      if (tx_pt || !t1) begin
        TX_FBIT <= TX_FBIT_IN;
      end else if (boc_tx_on && boc_state != BOC_IDLE && tx_frame[0]) begin
        TX_FBIT <= boc_bit;
      end else if (slc_on) begin
        TX_FBIT <= slc_bit;
      end else begin
        TX_FBIT <= TX_FBIT_IN;
      end
    end
  end

  // ==========================================
  // Transmit bit-oriented code generator
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      boc_state <= BOC_IDLE;
      boc_cnt <= 4'h0;
      send_bitcode_q <= 1'b0;
    end else if (CE) begin
      send_bitcode_q <= send_bitcode;
      if (send_bitcode && !send_bitcode_q && boc_tx_on) begin
        boc_state <= BOC_SEND;
        boc_cnt <= 4'h0;
      end else if (!boc_tx_on) begin
        boc_state <= BOC_IDLE;
      end else if (F_STB && tx_frame[0]) begin
        case (boc_state)
          BOC_SEND: begin
            boc_cnt <= boc_cnt + 4'h1;
            if (boc_cnt == BOC_LAST && !send_bitcode) begin
              boc_state <= BOC_ABORT;
            end
          end
          BOC_ABORT: begin
            boc_cnt <= boc_cnt + 4'h1;
            if (boc_cnt == BOC_LAST) begin
              boc_state <= BOC_IDLE;
            end
          end
          default: boc_state <= BOC_IDLE;
        endcase
      end
    end
  end

  // ==========================================
  // Receive multiframe synchroniser
  logic [71:0] hist, nhist;
  logic align_ok, rx_slc_on, rx_load;
  logic [23:0] rx_field;
  assign nhist = {hist[70:0], RX_FBIT};
  assign rx_slc_on = t1 && rx_ctrl1[B_RX_FRM] && rx_ctrl1[B_RX_CC] && rx_t1_ctrl2[B_RX_SLC_EN];
  assign rx_load = fstb && rx_slc_on && align_ok;

  // Newest bit is frame 71 of a candidate multiframe
  always_comb begin
    align_ok = 1'b1;
    rx_field = 24'h00_0000;
    for (int k = 0; k < 36; k++) begin
      if (nhist[71 - 2 * k] != ~k[0]) begin
        align_ok = 1'b0;
      end
      if (k < 12 && nhist[70 - 2 * k] != ALIGN_PAT[k]) begin
        align_ok = 1'b0;
      end
      if (k >= 12) begin
        rx_field[k - 12] = nhist[70 - 2 * k];
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      hist <= 72'h0;
      rx_msg <= {3{RST_REG}};
    end else if (fstb) begin
      hist <= nhist;
      if (rx_load) begin
        rx_msg <= rx_field;
      end
    end
  end

  // ==========================================
  // Receive bit-oriented code detector
  logic [15:0] bsr, nbsr;
  logic boc_hit, boc_det, dl_slot, clr_set, det_set;
  logic [5:0] last_code;
  logic [2:0] match_cnt;
  logic [7:0] absent_cnt, absent_lim;
  assign dl_slot = fstb && RX_DL_SLOT && t1 && !rx_ctrl1[B_RX_FRM];
  assign nbsr = {RX_FBIT, bsr[15:1]};
  assign boc_hit = (nbsr[15:8] == 8'hFF) && !nbsr[7] && !nbsr[0];
  assign absent_lim = {1'b0, 2'b00, 5'd0} + ({6'd0, rx_boc_ctrl[3:2]} + 8'd1) * 8'd32;
  assign det_set = dl_slot && boc_hit && !boc_det && (match_cnt + 3'd1 >= {rx_boc_ctrl[1:0], 1'b1}) &&
    (nbsr[6:1] == last_code || match_cnt == 3'd0);
  assign clr_set = dl_slot && !boc_hit && boc_det && (absent_cnt + 8'd1 >= absent_lim);

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      bsr <= 16'h0000;
      boc_det <= 1'b0;
      last_code <= 6'd0;
      match_cnt <= 3'd0;
      absent_cnt <= 8'd0;
      rx_boc_val <= RST_REG;
    end else if (dl_slot) begin
      bsr <= nbsr;
      if (boc_hit) begin
        absent_cnt <= 8'd0;
        last_code <= nbsr[6:1];
        if (nbsr[6:1] != last_code) begin
          match_cnt <= 3'd1;
        end else if (match_cnt != 3'd7) begin
          match_cnt <= match_cnt + 3'd1;
        end
        if (det_set) begin
          boc_det <= 1'b1;
          rx_boc_val <= {2'b00, nbsr[6:1]};
        end
      end else if (clr_set) begin
        boc_det <= 1'b0;
        match_cnt <= 3'd0;
        absent_cnt <= 8'd0;
      end else if (absent_cnt != 8'hFF) begin
        absent_cnt <= absent_cnt + 8'd1;
      end
    end
  end

  // ==========================================
  // Latched status, write one to clear, set wins
  logic wr_tls, wr_rls;
  assign wr_tls = wr_go && idx == IDX_TX_STAT1;
  assign wr_rls = wr_go && idx == IDX_RX_STAT7;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_stat1 <= RST_REG;
      rx_stat7 <= RST_REG;
    end else if (CE) begin
      tx_stat1 <= 8'((sent_set << B_TX_SENT) | (tx_stat1 & ~(wr_tls ? wd : 8'h00)));
      rx_stat7 <= 8'((rx_load << B_RX_UPD) | (det_set << B_BOC_DET) | (clr_set << B_BOC_CLR) |
        (rx_stat7 & ~(wr_rls ? wd : 8'h00)));
    end
  end

  // ==========================================
  // Checks
  mf_wrap_a: assert property (fstb && tx_frame == MF_LAST |=> tx_frame == 7'd0) else $error("frame count wrap");
  ft_pattern_a: assert property (fstb && slc_on && !tx_pt && boc_state == BOC_IDLE && !tx_frame[0]
    |=> TX_FBIT == ~$past(tx_frame[1])) else $error("Ft bit wrong");
  align_insert_a: assert property (fstb && slc_on && boc_state == BOC_IDLE && tx_frame[0] && fs_k < ALIGN_BITS
    |=> TX_FBIT == ALIGN_PAT[$past(fs_k[3:0])]) else $error("alignment bit wrong");
  msg_insert_a: assert property (fstb && slc_on && boc_state == BOC_IDLE && tx_frame[0] && fs_k >= ALIGN_BITS
    |=> TX_FBIT == $past(shadow[5'(fs_k - ALIGN_BITS)])) else $error("message bit wrong");
  sent_flag_a: assert property (sent_set |=> tx_stat1[B_TX_SENT]) else $error("sent flag missing");
  shadow_load_a: assert property (!$stable(shadow) |-> $past(fstb && tx_frame == 7'd0)) else $error("shadow moved");
  rx_update_a: assert property (rx_stat7[B_RX_UPD] && !$past(rx_stat7[B_RX_UPD]) |-> $past(align_ok && fstb))
    else $error("update without alignment");
  rx_coherent_a: assert property (!$stable(rx_msg) |-> $past(rx_load) && rx_stat7[B_RX_UPD])
    else $error("receive message torn");
  boc_start_a: assert property (CE && send_bitcode && !send_bitcode_q && boc_tx_on |=> boc_state == BOC_SEND && boc_cnt == 4'h0)
    else $error("code start late");
  boc_hold_a: assert property (CE && boc_state == BOC_SEND && send_bitcode && boc_tx_on |=> boc_state == BOC_SEND)
    else $error("code stopped early");
  e1_quiet_a: assert property (fstb && !t1 |=> TX_FBIT == $past(TX_FBIT_IN)) else $error("E1 F-bit changed");
  boc_detect_a: assert property (rx_stat7[B_BOC_DET] && !$past(rx_stat7[B_BOC_DET]) |-> $past(boc_hit && dl_slot))
    else $error("detect without code");
endmodule
`default_nettype wire

// ### core/tfd_pkg.sv
// Constants shared by the framer F-bit data link block
package tfd_pkg;
  // Register indices; byte address is four times the index
  localparam logic [12:0] IDX_RX_MSG1 = 13'h0064;
  localparam logic [12:0] IDX_RX_MSG2 = 13'h0065;
  localparam logic [12:0] IDX_RX_MSG3 = 13'h0066;
  localparam logic [12:0] IDX_RX_BOC_VAL = 13'h0063;
  localparam logic [12:0] IDX_RX_BOC_CTRL = 13'h0015;
  localparam logic [12:0] IDX_RX_STAT7 = 13'h0096;
  localparam logic [12:0] IDX_RX_CTRL1 = 13'h0010;
  localparam logic [12:0] IDX_RX_T1_CTRL2 = 13'h0014;
  localparam logic [12:0] IDX_MODE_CTRL = 13'h000F;
  localparam logic [12:0] IDX_TX_HDLC2 = 13'h0113;
  localparam logic [12:0] IDX_TX_FDL = 13'h0162;
  localparam logic [12:0] IDX_TX_BOC = 13'h0163;
  localparam logic [12:0] IDX_TX_MSG1 = 13'h0164;
  localparam logic [12:0] IDX_TX_MSG2 = 13'h0165;
  localparam logic [12:0] IDX_TX_MSG3 = 13'h0166;
  localparam logic [12:0] IDX_TX_CTRL1 = 13'h0181;
  localparam logic [12:0] IDX_TX_CTRL2 = 13'h0182;
  localparam logic [12:0] IDX_TX_CTRL3 = 13'h0183;
  localparam logic [12:0] IDX_TX_STAT1 = 13'h0190;
  localparam logic [12:0] FRAMER_STRIDE = 13'h0200;
  // Bit positions
  localparam int B_T1_MODE = 0;
  localparam int B_TX_SLC_EN = 6;
  localparam int B_TX_SRC = 7;
  localparam int B_TX_PT = 6;
  localparam int B_TX_FRM = 2;
  localparam int B_RX_FRM = 5;
  localparam int B_RX_CC = 3;
  localparam int B_RX_SLC_EN = 4;
  localparam int B_SEND_BITCODE = 6;
  localparam int B_TX_SENT = 4;
  localparam int B_RX_UPD = 3;
  localparam int B_BOC_DET = 0;
  localparam int B_BOC_CLR = 1;
  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h01;
  // Multiframe layout
  localparam logic [6:0] MF_LAST = 7'd71;
  localparam logic [5:0] ALIGN_BITS = 6'd12;
  localparam logic [11:0] ALIGN_PAT = 12'h1C7;
  localparam logic [3:0] BOC_LAST = 4'hF;
  typedef enum {BOC_IDLE, BOC_SEND, BOC_ABORT} tfd_boc_t;
endpackage

// ### tb/tfd_line_model.sv
// Far-end line model: frame strobes, receive F-bits and capture of sent F-bits
`timescale 1ns/10ps
`default_nettype none
module tfd_line_model (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // Line side
  output logic F_STB,
  output logic TX_FBIT_IN,
  output logic RX_FBIT,
  output logic RX_DL_SLOT,
  input wire logic TX_FBIT,
  input wire logic TX_MF_SYNC,
  // Bench side
  input wire logic [71:0] rx_pat,
  output logic [6:0] fr,
  output logic samp,
  output logic sbit,
  output logic ssync,
  output logic sin
);
  logic [3:0] cyc;
  logic rnd;
  logic [6:0] nxt;
  assign nxt = (fr == 7'd71) ? 7'd0 : fr + 7'd1;
  // ========================================
  // Frame timing and line data
  // Outside the strobe the lines carry the inverse of the last bit
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cyc <= 4'h0;
      fr <= 7'd71;
      F_STB <= 1'b0;
      sin <= 1'b0;
      TX_FBIT_IN <= 1'b0;
      RX_FBIT <= 1'b0;
      RX_DL_SLOT <= 1'b0;
    end else begin
      cyc <= cyc + 4'h1;
      F_STB <= (cyc == 4'hF);
      if (cyc == 4'hF) begin
        fr <= nxt;
        sin <= rnd;
        TX_FBIT_IN <= rnd;
        RX_FBIT <= rx_pat[nxt];
        RX_DL_SLOT <= nxt[0];
      end else begin
        TX_FBIT_IN <= ~sin;
        RX_FBIT <= ~rx_pat[fr];
      end
    end
  end
  always_ff @(posedge CLK) begin
    rnd <= 1'($urandom);
  end
  // ========================================
  // Capture of the sent F-bit, well after the strobe
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      samp <= 1'b0;
      sbit <= 1'b0;
      ssync <= 1'b0;
    end else begin
      samp <= (cyc == 4'h4);
      if (cyc == 4'h4) begin
        sbit <= TX_FBIT;
        ssync <= TX_MF_SYNC;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the F-bit data link block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import tfd_pkg::*;
  localparam int FN = 3;
  logic CLK, RST_B, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, F_STB, TX_FBIT_IN, RX_FBIT, RX_DL_SLOT;
  logic TX_FBIT, TX_MF_SYNC, samp, sbit, ssync, sin, er;
  logic [14:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [71:0] rx_pat, cb, cs;
  logic [6:0] fr;
  logic [23:0] m1, m2, r1;
  logic [5:0] code;
  int num_errors = 0;
  int n_checks = 0;
  int n;
  tfd_framer #(.FRAMER_NUM(FN)) i_tfd_framer (.CLK(CLK), .CE(1'b1), .RST_B(RST_B), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .F_STB(F_STB), .TX_FBIT_IN(TX_FBIT_IN), .RX_FBIT(RX_FBIT), .RX_DL_SLOT(RX_DL_SLOT),
    .TX_FBIT(TX_FBIT), .TX_MF_SYNC(TX_MF_SYNC));
  tfd_line_model i_tfd_line_model (.CLK(CLK), .RST_B(RST_B), .F_STB(F_STB), .TX_FBIT_IN(TX_FBIT_IN),
    .RX_FBIT(RX_FBIT), .RX_DL_SLOT(RX_DL_SLOT), .TX_FBIT(TX_FBIT), .TX_MF_SYNC(TX_MF_SYNC), .rx_pat(rx_pat),
    .fr(fr), .samp(samp), .sbit(sbit), .ssync(ssync), .sin(sin));
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  // ========================================
  // Reporting
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [71:0] seen, input logic [71:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic hang(input string what);
    $display("unexpected at %0t: %s", $time, what);
    num_errors++;
    print_verdict();
  endtask
  // ========================================
  // Expectations
  function automatic logic [12:0] fa(input logic [12:0] idx);
    return idx + FRAMER_STRIDE * 13'(FN - 1);
  endfunction
  function automatic logic [71:0] mf(input logic [23:0] m);
    logic [71:0] v;
    for (int f = 0; f < 72; f++) begin
      if (f % 2 == 0) begin
        v[f] = ((f / 2) % 2 == 0);
      end else if (f < 24) begin
        v[f] = ALIGN_PAT[(f - 1) / 2];
      end else begin
        v[f] = m[(f - 1) / 2 - 12];
      end
    end
    return v;
  endfunction
  function automatic logic bb(input int i);
    return (i > 7) ? 1'b1 : (i > 0 && i < 7) ? code[i - 1] : 1'b0;
  endfunction
  // ========================================
  // Bus and line tasks
  task automatic apb(input logic w, input logic [12:0] idx, input logic [7:0] d);
    int k;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= {idx, 2'b00};
    PWDATA <= {24'h000000, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    k = 0;
    @(posedge CLK);
    while (PREADY !== 1'b1 && k < 20) begin
      @(posedge CLK);
      k++;
    end
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (k == 20) begin
      hang("no bus answer");
    end
    @(posedge CLK);
  endtask
  task automatic wmsg(input logic [23:0] m);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, fa(IDX_TX_MSG1 + 13'(i)), m[8 * i +: 8]);
    end
  endtask
  task automatic next_samp();
    int k;
    k = 0;
    @(posedge CLK);
    while (samp !== 1'b1 && k < 40) begin
      @(posedge CLK);
      k++;
    end
    if (samp !== 1'b1) begin
      hang("no frame strobe");
    end
  endtask
  task automatic cap();
    int k;
    k = 0;
    do begin
      next_samp();
      k++;
    end while (fr != 7'd0 && k < 80);
    for (int f = 0; f < 72; f++) begin
      if (f > 0) begin
        next_samp();
      end
      cb[f] = sbit;
      cs[f] = ssync;
    end
  endtask
  // ========================================
  // Main sequence
  initial begin
    RST_B = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 15'h0000;
    PWDATA = 32'h00000000;
    void'($urandom(32'h7362));
    m1 = 24'($urandom);
    m2 = 24'($urandom);
    r1 = 24'($urandom);
    code = 6'($urandom);
    rx_pat = mf(r1);
    repeat (6) @(posedge CLK);
    RST_B <= 1'b1;
    @(posedge CLK);
    apb(1'b0, fa(IDX_MODE_CTRL), 8'h00);
    chk(rd, RST_MODE, "mode reset");
    apb(1'b0, fa(IDX_TX_MSG1), 8'h00);
    chk(rd, RST_REG, "message reset");
    apb(1'b0, IDX_TX_MSG1, 8'h00);
    chk(er, 1'b1, "first framer address");
    apb(1'b0, fa(13'h0001), 8'h00);
    chk({er, rd}, 33'h100000000, "unmapped read");
    $display("test registers done");
    apb(1'b1, fa(IDX_RX_CTRL1), 8'h28);
    apb(1'b1, fa(IDX_RX_T1_CTRL2), 8'h10);
    apb(1'b1, fa(IDX_TX_CTRL1), 8'h00);
    apb(1'b1, fa(IDX_TX_CTRL3), 8'h04);
    apb(1'b1, fa(IDX_TX_CTRL2), 8'h40);
    wmsg(m1);
    apb(1'b0, fa(IDX_TX_MSG2), 8'h00);
    chk(rd, m1[15:8], "message readback");
    cap();
    fork
      cap();
      begin
        repeat (30) next_samp();
        wmsg(m2);
      end
    join
    chk(cb, mf(m1), "multiframe during rewrite");
    chk(cs, 72'h1, "multiframe marker");
    apb(1'b0, fa(IDX_TX_STAT1), 8'h00);
    chk(rd[B_TX_SENT], 1'b1, "sent flag");
    apb(1'b1, fa(IDX_TX_STAT1), 8'h10);
    apb(1'b0, fa(IDX_TX_STAT1), 8'h00);
    chk(rd[B_TX_SENT], 1'b0, "sent flag cleared");
    cap();
    chk(cb, mf(m2), "new message");
    cap();
    chk(cb, mf(m2), "message resent");
    $display("test transmit multiframe done");
    rx_pat <= mf(r1) ^ 72'h8;
    apb(1'b0, fa(IDX_RX_STAT7), 8'h00);
    chk(rd[B_RX_UPD], 1'b1, "receive update");
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, fa(IDX_RX_MSG1 + 13'(i)), 8'h00);
      chk(rd, r1[8 * i +: 8], "receive message");
    end
    cap();
    apb(1'b1, fa(IDX_RX_STAT7), 8'h08);
    cap();
    apb(1'b0, fa(IDX_RX_STAT7), 8'h00);
    chk(rd[B_RX_UPD], 1'b0, "update without alignment");
    $display("test receive multiframe done");
    apb(1'b1, fa(IDX_TX_CTRL3), 8'h00);
    apb(1'b1, fa(IDX_TX_CTRL2), 8'h00);
    apb(1'b1, fa(IDX_TX_BOC), {2'b11, code});
    next_samp();
    apb(1'b1, fa(IDX_TX_HDLC2), 8'h40);
    n = 0;
    while (n < 80) begin
      next_samp();
      if (fr[0] == 1'b1) begin
        chk(sbit, n < 48 ? bb(n % 16) : n < 64 ? 1'b1 : sin, "code stream");
        n++;
        if (n == 36) begin
          apb(1'b1, fa(IDX_TX_HDLC2), 8'h00);
        end
      end
    end
    apb(1'b1, fa(IDX_MODE_CTRL), 8'h00);
    apb(1'b1, fa(IDX_TX_HDLC2), 8'h40);
    repeat (8) begin
      next_samp();
      chk(sbit, sin, "no code outside T1");
    end
    $display("test bit-oriented code done");
    print_verdict();
  end
endmodule
`default_nettype wire
